// *** smt_defines.svh ***
/*
  constants for the static memory strobe timing block.
  assumes inclusion by bare name from package and design file.
*/
`ifndef SMT_DEFINES_SVH
`define SMT_DEFINES_SVH
`define SMT_ADDR_W 24
`define SMT_DATA_W 16
`define SMT_CNT_W 4
`define SMT_PH_W 8
`define SMT_MODE_ASYNC 2'b00
`define SMT_MODE_BURST 2'b11
`define SMT_RDY_RELEASE 8'h03
`define SMT_CNT_MAX 8'hff
`endif

// *** smt_pkg.sv ***
/*
  types for the static memory strobe timing block.
  assumes smt_defines.svh is on the include path.
*/
`include "smt_defines.svh"
package smt_pkg;
  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_PRE = 10'h002,
    ST_SETUP = 10'h004,
    ST_PACC = 10'h008,
    ST_ACC = 10'h010,
    ST_HOLD = 10'h020,
    ST_TURN = 10'h040,
    ST_BWAIT = 10'h080,
    ST_BADDR = 10'h100,
    ST_BDATA = 10'h200
  } state_t;

  typedef struct packed {
    state_t st;
    logic [`SMT_PH_W-1:0] cnt;
    logic [`SMT_CNT_W-1:0] word;
    logic wr;
    logic flash;
    logic bst;
    logic seen;
    logic [`SMT_ADDR_W-1:0] addr;
    logic [`SMT_DATA_W-1:0] wdata;
    logic [1:0] ben_n;
    logic cs_n;
    logic re_n;
    logic we_n;
    logic oe_n;
    logic adv_n;
    logic doe;
    logic bclk;
    logic [1:0] ph;
    logic rvld;
    logic [`SMT_DATA_W-1:0] rdata;
    logic r1;
    logic r2;
    logic r3;
    logic rdy_f;
    logic busy;
  } regs_t;
endpackage

// *** static_memory_strobe_timing.sv ***
/*
  strobe sequencer for an external static memory: page-mode read,
  synchronous burst flash read, asynchronous and flash write.
  assumes timing counts and mode inputs stay stable while busy_out
  is high, and one request pulse per access while busy_out is low.
*/
//
// Functional notes
// - burst clock is system clock over divider+1, for divider 1 to 3
// - bank type 11 selects synchronous burst read
// - bank type 00 selects asynchronous memory write
// - first address held pre, setup, preaccess, access counts total
// - later page addresses held page wait count
// - read strobe low access plus page waits
// - address valid low for read setup count
// - hold address, select, enable after read strobe
// - burst data and wait sampled on clock rise
// - burst outputs launched on burst clock rise
// - burst clock reaches pin only during burst
// - write strobe follows pre, setup, preaccess counts
// - write strobe low exactly write access count when ready sense is off
// - hold data, address, selects after write strobe
// - data bus driven exactly while select asserted on writes
// - write strobe rises three cycles after ready
// - flash write: address valid after pre setup
// - flash write strobe after preaccess count
// - select idle at least idle plus transition
`timescale 1ns/1ns
`include "smt_defines.svh"
module static_memory_strobe_timing (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [`SMT_ADDR_W-1:0] req_addr_in,
  input wire logic [`SMT_DATA_W-1:0] req_wdata_in,
  input wire logic [1:0] req_byte_en_in,
  input wire logic [1:0] bank_access_type_in,
  input wire logic [`SMT_CNT_W-1:0] words_read_count_in,
  input wire logic [`SMT_CNT_W-1:0] pre_setup_count_in,
  input wire logic [`SMT_CNT_W-1:0] read_setup_count_in,
  input wire logic [`SMT_CNT_W-1:0] write_setup_count_in,
  input wire logic [`SMT_CNT_W-1:0] pre_access_count_in,
  input wire logic [`SMT_CNT_W-1:0] read_access_count_in,
  input wire logic [`SMT_CNT_W-1:0] write_access_count_in,
  input wire logic [`SMT_CNT_W-1:0] read_hold_count_in,
  input wire logic [`SMT_CNT_W-1:0] write_hold_count_in,
  input wire logic [`SMT_CNT_W-1:0] page_wait_count_in,
  input wire logic [`SMT_CNT_W-1:0] idle_count_in,
  input wire logic [`SMT_CNT_W-1:0] transition_count_in,
  input wire logic ready_sense_enable_in,
  input wire logic [1:0] burst_divider_in,
  input wire logic memory_ready_input_in,
  input wire logic flash_wait_in,
  input wire logic [`SMT_DATA_W-1:0] mem_data_in,
  output logic busy_out,
  output logic rd_valid_out,
  output logic [`SMT_DATA_W-1:0] rd_data_out,
  output logic [`SMT_ADDR_W-1:0] memory_address_lines_out,
  output logic bank_chip_select_n_out,
  output logic read_strobe_n_out,
  output logic write_strobe_n_out,
  output logic output_enable_strobe_n_out,
  output logic address_valid_strobe_n_out,
  output logic [1:0] byte_lane_enables_n_out,
  output logic [`SMT_DATA_W-1:0] mem_data_out,
  output logic mem_data_oe_out,
  output logic burst_flash_clock_out
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // a zero count still costs one cycle, keeps every phase visible
  function automatic logic [`SMT_PH_W-1:0] ld(
    input logic [`SMT_CNT_W-1:0] v
  );
    ld = (v == '0) ? 8'h01 : {4'h0, v};
  endfunction

  smt_pkg::regs_t s_q;
  smt_pkg::regs_t s_d;
  logic rise;
  logic [`SMT_PH_W-1:0] turn_cnt;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  // burst clock phase: free running, one rise per divider+1 cycles
  assign rise = (s_q.ph == burst_divider_in);
  assign turn_cnt = ld(idle_count_in) + ld(transition_count_in);

  always_comb begin
    s_d = s_q;
    s_d.rvld = 1'b0;
    s_d.ph = rise ? 2'b00 : s_q.ph + 2'b01;
    // ready pin: change accepted once stages two and three agree
    s_d.r1 = memory_ready_input_in;
    s_d.r2 = s_q.r1;
    s_d.r3 = s_q.r2;
    if (s_q.r2 == s_q.r3) begin
      s_d.rdy_f = s_q.r3;
    end
    if (s_q.cnt > 8'h01) begin
      s_d.cnt = s_q.cnt - 8'h01;
    end
    unique case (s_q.st)
      smt_pkg::ST_IDLE: begin
        if (req_valid_in) begin
          s_d.busy = 1'b1;
          s_d.wr = req_write_in;
          s_d.addr = req_addr_in;
          s_d.wdata = req_wdata_in;
          s_d.word = (words_read_count_in == '0) ? 4'h1
                                                 : words_read_count_in;
          s_d.seen = 1'b0;
          s_d.flash = (bank_access_type_in != `SMT_MODE_ASYNC);
          if (!req_write_in &&
              bank_access_type_in == `SMT_MODE_BURST) begin
            s_d.bst = 1'b1;
            s_d.st = smt_pkg::ST_BWAIT;
          end else begin
            // select, address and write data go out together
            s_d.bst = 1'b0;
            s_d.cs_n = 1'b0;
            s_d.ben_n = ~req_byte_en_in;
            s_d.doe = req_write_in;
            s_d.cnt = ld(pre_setup_count_in);
            s_d.st = smt_pkg::ST_PRE;
          end
        end
      end
      smt_pkg::ST_PRE: begin
        if (s_q.cnt == 8'h01) begin
          s_d.st = smt_pkg::ST_SETUP;
          if (s_q.wr) begin
            s_d.cnt = ld(write_setup_count_in);
            s_d.adv_n = !s_q.flash;
          end else begin
            s_d.cnt = ld(read_setup_count_in);
            s_d.adv_n = 1'b0;
            s_d.oe_n = 1'b0;
          end
        end
      end
      smt_pkg::ST_SETUP: begin
        if (s_q.cnt == 8'h01) begin
          s_d.adv_n = 1'b1;
          s_d.cnt = ld(pre_access_count_in);
          s_d.st = smt_pkg::ST_PACC;
        end
      end
      smt_pkg::ST_PACC: begin
        if (s_q.cnt == 8'h01) begin
          s_d.st = smt_pkg::ST_ACC;
          if (s_q.wr) begin
            s_d.we_n = 1'b0;
            s_d.cnt = ld(write_access_count_in);
          end else begin
            s_d.re_n = 1'b0;
            s_d.cnt = ld(read_access_count_in);
          end
        end
      end
      smt_pkg::ST_ACC: begin
        if (s_q.wr) begin
          if (ready_sense_enable_in) begin
            // ready alone ends the strobe; the access count is overridden
            if (s_q.rdy_f && !s_q.seen) begin
              s_d.seen = 1'b1;
              s_d.cnt = `SMT_RDY_RELEASE;
            end else if (s_q.seen && s_q.cnt == 8'h01) begin
              s_d.we_n = 1'b1;
              s_d.cnt = ld(write_hold_count_in);
              s_d.st = smt_pkg::ST_HOLD;
            end
          end else if (s_q.cnt == 8'h01) begin
            s_d.we_n = 1'b1;
            s_d.cnt = ld(write_hold_count_in);
            s_d.st = smt_pkg::ST_HOLD;
          end
        end else if (s_q.cnt == 8'h01) begin
          // page read: one word per access or page wait span
          s_d.rdata = mem_data_in;
          s_d.rvld = 1'b1;
          if (s_q.word == 4'h1) begin
            s_d.re_n = 1'b1;
            s_d.cnt = ld(read_hold_count_in);
            s_d.st = smt_pkg::ST_HOLD;
          end else begin
            s_d.word = s_q.word - 4'h1;
            s_d.addr = s_q.addr + 24'h000001;
            s_d.cnt = ld(page_wait_count_in);
          end
        end
      end
      smt_pkg::ST_HOLD: begin
        if (s_q.cnt == 8'h01) begin
          // everything held through the hold span drops together
          s_d.cs_n = 1'b1;
          s_d.oe_n = 1'b1;
          s_d.ben_n = 2'b11;
          s_d.doe = 1'b0;
          s_d.cnt = turn_cnt;
          s_d.st = smt_pkg::ST_TURN;
        end
      end
      smt_pkg::ST_TURN: begin
        if (s_q.cnt == 8'h01) begin
          s_d.busy = 1'b0;
          s_d.bst = 1'b0;
          s_d.st = smt_pkg::ST_IDLE;
        end
      end
      smt_pkg::ST_BWAIT: begin
        if (rise) begin
          s_d.cs_n = 1'b0;
          s_d.adv_n = 1'b0;
          s_d.re_n = 1'b0;
          s_d.oe_n = 1'b0;
          s_d.st = smt_pkg::ST_BADDR;
        end
      end
      smt_pkg::ST_BADDR: begin
        if (rise) begin
          s_d.adv_n = 1'b1;
          s_d.st = smt_pkg::ST_BDATA;
        end
      end
      smt_pkg::ST_BDATA: begin
        // wait asserted high by the flash holds off the sample
        if (rise && !flash_wait_in) begin
          s_d.rdata = mem_data_in;
          s_d.rvld = 1'b1;
          s_d.word = s_q.word - 4'h1;
          if (s_q.word == 4'h1) begin
            s_d.cs_n = 1'b1;
            s_d.re_n = 1'b1;
            s_d.oe_n = 1'b1;
            s_d.cnt = turn_cnt;
            s_d.st = smt_pkg::ST_TURN;
          end
        end
      end
    endcase
    // pin shows the high half only while the burst is running
    s_d.bclk = (s_d.st == smt_pkg::ST_BADDR ||
                s_d.st == smt_pkg::ST_BDATA) &&
               (s_d.ph <= (burst_divider_in >> 1));
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      s_q <= '0;
      s_q.st <= smt_pkg::ST_IDLE;
      s_q.cs_n <= 1'b1;
      s_q.re_n <= 1'b1;
      s_q.we_n <= 1'b1;
      s_q.oe_n <= 1'b1;
      s_q.adv_n <= 1'b1;
      s_q.ben_n <= 2'b11;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign busy_out = s_q.busy;
  assign rd_valid_out = s_q.rvld;
  assign rd_data_out = s_q.rdata;
  assign memory_address_lines_out = s_q.addr;
  assign bank_chip_select_n_out = s_q.cs_n;
  assign read_strobe_n_out = s_q.re_n;
  assign write_strobe_n_out = s_q.we_n;
  assign output_enable_strobe_n_out = s_q.oe_n;
  assign address_valid_strobe_n_out = s_q.adv_n;
  assign byte_lane_enables_n_out = s_q.ben_n;
  assign mem_data_out = s_q.wdata;
  assign mem_data_oe_out = s_q.doe;
  assign burst_flash_clock_out = s_q.bclk;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [`SMT_PH_W-1:0] we_lo;
  logic [`SMT_PH_W-1:0] adv_lo;
  logic [`SMT_PH_W-1:0] cs_hi;
  logic [`SMT_PH_W-1:0] aft;

  // run lengths of strobe levels, read only by the checks
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      we_lo <= 8'h00;
      adv_lo <= 8'h00;
      cs_hi <= `SMT_CNT_MAX; // reset counts as a long idle gap
      aft <= 8'h00;
    end else begin
      we_lo <= write_strobe_n_out ? 8'h00 : we_lo + 8'h01;
      adv_lo <= address_valid_strobe_n_out ? 8'h00 : adv_lo + 8'h01;
      if (!bank_chip_select_n_out) begin
        cs_hi <= 8'h00;
      end else if (cs_hi != `SMT_CNT_MAX) begin
        cs_hi <= cs_hi + 8'h01;
      end
      if (!read_strobe_n_out || !write_strobe_n_out) begin
        aft <= 8'h00;
      end else if (!bank_chip_select_n_out) begin
        aft <= aft + 8'h01;
      end
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);

  chk_we_width: assert property (
    $rose(write_strobe_n_out) && !ready_sense_enable_in
    |-> we_lo == ld(write_access_count_in))
    else $error("write strobe width wrong");
  chk_hold_len: assert property (
    $rose(bank_chip_select_n_out) && !s_q.bst
    |-> aft == (s_q.wr ? ld(write_hold_count_in)
                       : ld(read_hold_count_in)))
    else $error("hold after strobe wrong");
  chk_turn_gap: assert property (
    $fell(bank_chip_select_n_out) |-> cs_hi >= turn_cnt)
    else $error("select idle gap too short");
  chk_adv_width: assert property (
    $rose(address_valid_strobe_n_out) && !s_q.bst
    |-> adv_lo == (s_q.wr ? ld(write_setup_count_in)
                          : ld(read_setup_count_in)))
    else $error("address valid width wrong");
  chk_data_drive: assert property (
    mem_data_oe_out |-> !bank_chip_select_n_out && s_q.wr)
    else $error("data driven without select");
  chk_ready_release: assert property (
    s_q.st == smt_pkg::ST_ACC && s_q.wr && ready_sense_enable_in
    && s_q.rdy_f && !s_q.seen
    |-> !write_strobe_n_out [*4] ##1 write_strobe_n_out)
    else $error("write strobe release after ready wrong");
  chk_burst_pin: assert property (
    burst_flash_clock_out |-> s_q.bst && !bank_chip_select_n_out)
    else $error("burst clock outside burst");
  chk_burst_mode: assert property (
    s_q.st == smt_pkg::ST_IDLE && req_valid_in && !req_write_in
    && bank_access_type_in == `SMT_MODE_BURST
    |=> s_q.st == smt_pkg::ST_BWAIT && busy_out)
    else $error("burst mode not entered");

  cov_burst: cover property (
    s_q.st == smt_pkg::ST_BDATA ##1 s_q.st == smt_pkg::ST_TURN);
  cov_page: cover property (
    !read_strobe_n_out && $changed(memory_address_lines_out));
  cov_ready: cover property (
    s_q.seen && $rose(write_strobe_n_out));
  cov_flash_wr: cover property (
    s_q.wr && $rose(address_valid_strobe_n_out));
endmodule

// *** mem_model.sv ***
/*
  behavioural external static memory / burst flash for the strobe bench.
  assumes the strobe block drives it directly, no board delays.
*/
`timescale 1ns/1ns
module mem_model #(
  parameter int RDY_DLY = 3
) (
  input wire logic mclk_in,
  input wire logic cs_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  input wire logic [23:0] addr_in,
  output logic ready_out,
  output logic wait_out,
  output logic [15:0] data_out
);
  logic [3:0] wcnt_q = 4'h0;
  logic [15:0] junk_q = 16'h3c3c;

  // ----------------------------------------
  // strobe age and released-bus pattern
  // ----------------------------------------
  // junk toggles every cycle so a stale bus never looks valid
  always @(posedge mclk_in) begin
    junk_q <= ~junk_q;
    if (we_n_in) begin
      wcnt_q <= 4'h0;
    end else if (wcnt_q != 4'hf) begin
      wcnt_q <= wcnt_q + 4'h1;
    end
  end

  // ready drops while selected, returns a fixed delay after strobe
  assign ready_out = cs_n_in | (~we_n_in & (wcnt_q >= RDY_DLY));
  // no wait states while selected; noise when not selected
  assign wait_out = cs_n_in ? junk_q[0] : 1'b0;
  // read data follows the address only while output enabled
  assign data_out = oe_n_in ? junk_q : (addr_in[15:0] ^ 16'ha5c3);
endmodule

// *** tb.sv ***
/*
  self-checking bench for the static memory strobe sequencer.
  assumes mem_model.sv and the design files compile alongside.
*/
`timescale 1ns/1ns
module tb;
  logic mclk_in = 1'b0;
  logic reset_n = 1'b0;
  logic req_valid = 1'b0, req_write = 1'b0, rdy_en = 1'b0, burst = 1'b0;
  logic [23:0] req_addr = 24'h0, rd_base = 24'h0;
  logic [15:0] req_wdata = 16'h0, dat_at_we;
  logic [1:0] btype = 2'b00, bdiv = 2'b00;
  logic [3:0] pst = 4'h2, rsc = 4'h2, write_setup_count = 4'h3, pac = 4'h1, rac = 4'h3;
  logic [3:0] wac = 4'h4, read_hold_count = 4'h2, write_hold_count = 4'h2, pgw = 4'h2, itc = 4'h1;
  logic [3:0] ttc = 4'h2, nw = 4'h3;
  logic busy, rdv, cs, re, we, oe, adv, doe, bclk, rdy, wt, oe_at_we;
  logic clk_at_csf;
  logic [15:0] rdat, mdo, mdi;
  logic [23:0] addr, pa;
  logic [1:0] ben, ben_at_we, ben_req = 2'b11;
  logic pcs = 1, pwe = 1, padv = 1, pre = 1, prdy = 1, pclk = 0, poe = 1;
  int cyc, t_csf, t_csr, t_wef, t_wer, t_advf, t_advr, t_ref, t_rer, t_rdy;
  int gap, nval, t_clk, per, err_count, checks_done, t_oer;
  int at[$];

  static_memory_strobe_timing u_dut (.mclk_in(mclk_in),
    .reset_n_in(reset_n), .req_valid_in(req_valid), .req_write_in(req_write),
    .req_addr_in(req_addr), .req_wdata_in(req_wdata),
    .req_byte_en_in(ben_req), .bank_access_type_in(btype),
    .words_read_count_in(nw), .pre_setup_count_in(pst),
    .read_setup_count_in(rsc), .write_setup_count_in(write_setup_count),
    .pre_access_count_in(pac), .read_access_count_in(rac),
    .write_access_count_in(wac), .read_hold_count_in(read_hold_count),
    .write_hold_count_in(write_hold_count), .page_wait_count_in(pgw),
    .idle_count_in(itc), .transition_count_in(ttc),
    .ready_sense_enable_in(rdy_en), .burst_divider_in(bdiv),
    .memory_ready_input_in(rdy), .flash_wait_in(wt), .mem_data_in(mdi),
    .busy_out(busy), .rd_valid_out(rdv), .rd_data_out(rdat),
    .memory_address_lines_out(addr), .bank_chip_select_n_out(cs),
    .read_strobe_n_out(re), .write_strobe_n_out(we),
    .output_enable_strobe_n_out(oe), .address_valid_strobe_n_out(adv),
    .byte_lane_enables_n_out(ben), .mem_data_out(mdo),
    .mem_data_oe_out(doe), .burst_flash_clock_out(bclk));

  mem_model u_mem (.mclk_in(mclk_in), .cs_n_in(cs), .oe_n_in(oe),
    .we_n_in(we), .addr_in(addr), .ready_out(rdy), .wait_out(wt),
    .data_out(mdi));

  always #4 mclk_in = ~mclk_in;

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task end_sim();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // edge monitor: event times in cycles
  // ----------------------------------------
  // reads pre-edge outputs, so all widths share one reference
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc > 5000) begin
      err_count++;
      end_sim();
    end
    if (pcs && !cs) begin
      t_csf = cyc; gap = cyc - t_csr; clk_at_csf = bclk;
      at.delete(); pa = addr; at.push_back(cyc);
    end
    if (!pcs && cs) t_csr = cyc;
    if (!cs && addr !== pa) begin
      at.push_back(cyc); pa = addr;
    end
    if (pwe && !we) begin
      t_wef = cyc; oe_at_we = doe;
    end
    if (!pwe && we) begin
      t_wer = cyc; dat_at_we = mdo; ben_at_we = ben;
    end
    if (padv && !adv) t_advf = cyc;
    if (!padv && adv) t_advr = cyc;
    if (pre && !re) t_ref = cyc;
    if (!pre && re) t_rer = cyc;
    if (!poe && oe) t_oer = cyc;
    if (!prdy && rdy && !cs) t_rdy = cyc;
    if (!pclk && bclk) begin
      per = cyc - t_clk; t_clk = cyc;
    end
    if (rdv === 1'b1) begin
      check(rdat, (rd_base + (burst ? 0 : nval)) ^ 16'ha5c3);
      nval++;
    end
    if (reset_n) check(doe & cs, 0);
    if (reset_n) check(bclk & cs, 0);
    pcs = cs; pwe = we; padv = adv; pre = re; prdy = rdy; pclk = bclk;
    poe = oe;
  end

  // one access: pulse request, then wait for busy to drop
  task automatic acc(input logic wr, input logic [1:0] ty,
                     input logic [23:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge mclk_in);
    nval = 0; rd_base = a; burst = (ty == 2'b11) & ~wr;
    req_valid <= 1'b1; req_write <= wr; btype <= ty;
    req_addr <= a; req_wdata <= d;
    @(posedge mclk_in);
    req_valid <= 1'b0;
    @(posedge mclk_in);
    while (busy !== 1'b0 && n < 300) begin
      @(posedge mclk_in);
      n++;
    end
    if (n >= 300) err_count++;
  endtask

  initial begin
    repeat (8) @(posedge mclk_in);
    reset_n <= 1'b1;
    // back-to-back plain writes, ready ignored
    acc(1'b1, 2'b00, 24'h000120, 16'hbeef);
    acc(1'b1, 2'b00, 24'h000121, 16'h1234);
    check(t_wef - t_csf, 6);
    check(t_wer - t_wef, 4);
    check(t_csr - t_wer, 2);
    check(dat_at_we, 16'h1234);
    check(ben_at_we, 2'b00);
    check(oe_at_we, 1);
    check(gap >= 3, 1);
    check(t_advf < t_csf, 1);
    $display("test async write done");
    // flash write: address-valid pulse before the strobe, one lane only
    ben_req <= 2'b10;
    acc(1'b1, 2'b01, 24'h000200, 16'h5a5a);
    ben_req <= 2'b11;
    check(ben_at_we, 2'b01);
    check(t_advf - t_csf, 2);
    check(t_advr - t_advf, 3);
    check(t_wef - t_advr, 1);
    check(t_wer - t_wef, 4);
    $display("test flash write done");
    // ready ends the strobe before the longest count would
    rdy_en <= 1'b1; wac <= 4'hf;
    acc(1'b1, 2'b00, 24'h000300, 16'hc0de);
    // pin to release: three sync flops, filter, detect, three-cycle release
    check(t_wer - t_rdy, 8);
    check(t_wer - t_wef < 15, 1);
    rdy_en <= 1'b0;
    $display("test ready write done");
    // page read of three words
    acc(1'b0, 2'b00, 24'h000340, 16'h0000);
    check(at[1] - at[0], 8);
    check(at[2] - at[1], 2);
    check(t_rer - t_ref, 7);
    check(t_advr - t_advf, 2);
    check(t_csr - t_rer, 2);
    check(t_oer - t_rer, 2);
    check(nval, 3);
    $display("test page read done");
    // burst read at every divider setting
    nw <= 4'h4;
    for (int d = 0; d < 4; d++) begin
      bdiv <= d[1:0];
      acc(1'b0, 2'b11, 24'h000400 + 24'(d), 16'h0000);
      check(nval, 4);
      check(clk_at_csf, 1);
      if (d > 0) check(per, d + 1);
    end
    $display("test burst read done");
    end_sim();
  end
endmodule
